//--- hdl/lre_consts.svh
// Constants of the ladder relay evaluator: map, fields, resets and timing
//
// Overview of operation
// R1 - Verdict follows programmable relay, else final relay
// R2 - Either camera out of limits clears alarm relay
// R3 - Processing error sets error relay, some codes excepted
// R4 - Done sets done relay; new start clears it
// R5 - Each clear relay clears its own counter
// R6 - Program drives clears after counter rung only
// R7 - Seven external input terminals readable as contacts
// R8 - Timer terminal on at timeout, off on input
// R9 - Counter terminal on at count, held until clear
// R10 - Calculation terminals follow their OK/NG results
// R11 - Output terminals readable back as contacts
// R12 - Normally-open contact conducts when input on
// R13 - Normally-closed contact conducts when input off
// R14 - Branch contacts join paths as logical OR
// R15 - One program per object type 0..15
// R16 - Final relay needs all items OK, no error
// R17 - Rungs evaluated in order, series AND, then outputs
`ifndef LRE_CONSTS_SVH
`define LRE_CONSTS_SVH
// ==========================================================
// Register byte offsets
`define LRE_REG_CTRL      8'h00
`define LRE_REG_STATUS    8'h04
`define LRE_REG_IRQ_STAT  8'h08
`define LRE_REG_IRQ_MASK  8'h0c
`define LRE_REG_LIGHT0    8'h10
`define LRE_REG_LIGHT1    8'h14
`define LRE_REG_PROG_ADDR 8'h18
`define LRE_REG_PROG_DATA 8'h1c
`define LRE_REG_OUTPUTS   8'h20
`define LRE_REG_TERMS     8'h24
// ==========================================================
// Reset values
`define LRE_CTRL_RST      32'h0000_0000
`define LRE_LIGHT_RST     16'hff00
// ==========================================================
// Signal space of contact sources and coil targets
`define LRE_SRC_X         8'h80
`define LRE_SRC_TM        8'h88
`define LRE_SRC_CN        8'h90
`define LRE_SRC_AN        8'ha0
`define LRE_SRC_Y         8'hb0
`define LRE_RLY_FINAL     7'd112
`define LRE_RLY_PROG      7'd116
`define LRE_RLY_LIGHT     7'd117
`define LRE_RLY_ERROR     7'd118
`define LRE_RLY_DONE      7'd119
`define LRE_RLY_CLR0      120
// ==========================================================
// Program word fields
`define LRE_COIL_SLOT     4'h8
`define LRE_PRESET_LSB    10
// Error end codes that do not raise the error relay
`define LRE_ERR_EX0       8'h34
`define LRE_ERR_EX1       8'h35
`define LRE_ERR_EX2       8'h36
`define LRE_ERR_EX3       8'h3e
// ==========================================================
// Timing: timer base period and clock period
`define LRE_TMR_BASE_NS   10000000
`define LRE_CLK_NS        100
`define LRE_TICK_CYC      (`LRE_TMR_BASE_NS / `LRE_CLK_NS)
`endif

//--- hdl/lre_pkg.sv
// Types of the ladder relay evaluator
package lre_pkg;
	typedef enum logic [2:0] {
		LRE_K_NONE, LRE_K_NO, LRE_K_NC, LRE_K_OR_NO, LRE_K_OR_NC
	} lre_kind_t;
	typedef enum logic [1:0] {
		LRE_O_NONE, LRE_O_COIL, LRE_O_TIMER, LRE_O_COUNTER
	} lre_okind_t;
	typedef struct packed {
		logic [20:0] rsvd;
		lre_kind_t   kind;
		logic [7:0]  src;
	} lre_contact_t;
	typedef struct packed {
		logic [11:0] rsvd;
		logic [9:0]  preset;
		lre_okind_t  okind;
		logic [7:0]  target;
	} lre_coil_t;
	typedef struct packed {
		logic       start;
		logic       done;
		logic       err;
		logic [7:0] err_code;
		logic       items_ok;
	} lre_meas_t;
	typedef struct packed {
		logic [7:0] cam0;
		logic [7:0] cam1;
	} lre_light_t;
endpackage

//--- hdl/lre_evaluator.sv
// Ladder relay evaluator with Avalon-MM register slave
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "lre_consts.svh"
module lre_evaluator #(
	parameter int TICK_CYC = `LRE_TICK_CYC,
	parameter int RUNGS    = 16
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	// Avalon-MM slave
	input  wire logic [7:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	// Measurement engine
	input  wire lre_pkg::lre_meas_t  meas,
	input  wire lre_pkg::lre_light_t illum,
	input  wire logic [15:0]       calc_result_terminals,
	// Pins and results
	input  wire logic [6:0]        external_input_terminals,
	output logic [15:0]            output_terminals,
	output logic                   verdict_ok,
	output logic                   irq
);
	import lre_pkg::*;

	typedef enum {S_IDLE, S_SCAN, S_FINISH} lre_state_t;

	// ==========================================================
	// Storage and state
	logic [31:0]  prog_mem [0:4095];
	logic [31:0]  ctrl_ff;
	logic [2:0]   irq_stat_ff, irq_mask_ff;
	logic [15:0]  light0_ff, light1_ff;
	logic [11:0]  prog_addr_ff;
	logic         wait_ff;
	logic [31:0]  rdata_ff;
	logic [127:0] c_ff;
	logic [15:0]  y_ff, y_out_ff;
	logic         verdict_ff, irq_ff, prog_used_ff;
	logic [6:0]   x_s1_ff, x_s2_ff, x_s3_ff, x_ff;
	logic [7:0]   tm_term, cn_term;
	logic [7:0]   tm_in_ff;
	logic [9:0]   tm_pre_ff [0:7];
	logic [7:0]   cn_hit_ff, cn_val_ff;
	logic [9:0]   cn_pre_ff [0:7];
	lre_state_t   state_ff;
	logic [3:0]   rung_ff, slot_ff;
	logic         ser_ff, par_ff, any_ff;
	logic [16:0]  tick_cnt_ff;
	logic         tick_ff;

	// ==========================================================
	// Bus decode
	wire        bus_req  = avs_read | avs_write;
	wire        bus_do_w = avs_write & ~wait_ff;
	wire [3:0]  obj_type = ctrl_ff[7:4];
	wire        scan_en  = ctrl_ff[0];

	// One wait state on every access, so array reads have a full cycle
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_ff <= 1'b1;
		end else begin
			wait_ff <= !(bus_req && wait_ff);
		end
	end

	// Read data is captured during the wait state
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff <= 32'h0000_0000;
		end else if (avs_read && wait_ff) begin
			unique case (avs_address)
				`LRE_REG_CTRL:      rdata_ff <= ctrl_ff;
				`LRE_REG_STATUS:    rdata_ff <= {24'h00_0000, c_ff[119:116],
					c_ff[`LRE_RLY_FINAL], verdict_ff, prog_used_ff, state_ff != S_IDLE};
				`LRE_REG_IRQ_STAT:  rdata_ff <= {29'h0, irq_stat_ff};
				`LRE_REG_IRQ_MASK:  rdata_ff <= {29'h0, irq_mask_ff};
				`LRE_REG_LIGHT0:    rdata_ff <= {16'h0000, light0_ff};
				`LRE_REG_LIGHT1:    rdata_ff <= {16'h0000, light1_ff};
				`LRE_REG_PROG_ADDR: rdata_ff <= {20'h0_0000, prog_addr_ff};
				`LRE_REG_PROG_DATA: rdata_ff <= prog_mem[prog_addr_ff];
				`LRE_REG_OUTPUTS:   rdata_ff <= {16'h0000, y_out_ff};
				`LRE_REG_TERMS:     rdata_ff <= {16'h0000, cn_term, tm_term};
				default:            rdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	// Control and limit registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_ff     <= `LRE_CTRL_RST;
			irq_mask_ff <= 3'h0;
			light0_ff   <= `LRE_LIGHT_RST;
			light1_ff   <= `LRE_LIGHT_RST;
		end else if (bus_do_w) begin
			if (avs_address == `LRE_REG_CTRL)
				ctrl_ff <= {24'h00_0000, avs_writedata[7:4], 3'h0, avs_writedata[0]};
			if (avs_address == `LRE_REG_IRQ_MASK)
				irq_mask_ff <= avs_writedata[2:0];
			if (avs_address == `LRE_REG_LIGHT0)
				light0_ff <= avs_writedata[15:0];
			if (avs_address == `LRE_REG_LIGHT1)
				light1_ff <= avs_writedata[15:0];
		end
	end

	// Program store; the data port walks the address so a whole program loads in a burst
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			prog_addr_ff <= 12'h000;
		end else if (bus_do_w && avs_address == `LRE_REG_PROG_ADDR) begin
			prog_addr_ff <= avs_writedata[11:0];
		end else if (bus_do_w && avs_address == `LRE_REG_PROG_DATA) begin
			prog_addr_ff <= prog_addr_ff + 12'h001;
		end
	end

	// Memory has no reset; software loads every program it selects
	always_ff @(posedge sys_clk) begin
		if (bus_do_w && avs_address == `LRE_REG_PROG_DATA)
			prog_mem[prog_addr_ff] <= avs_writedata;
	end

	// ==========================================================
	// External inputs: three stages, a change counts when stages two and three agree
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			x_s1_ff <= 7'h00;
			x_s2_ff <= 7'h00;
			x_s3_ff <= 7'h00;
			x_ff    <= 7'h00;
		end else begin
			x_s1_ff <= external_input_terminals;
			x_s2_ff <= x_s1_ff;
			x_s3_ff <= x_s2_ff;
			for (int i = 0; i < 7; i++) begin
				if (x_s2_ff[i] == x_s3_ff[i])
					x_ff[i] <= x_s3_ff[i];
			end
		end
	end

	// ==========================================================
	// Contact source space: relays, inputs, timers, counters, results, outputs
	wire [255:0] src_vec = {64'h0, y_ff, calc_result_terminals, 8'h00, cn_term, tm_term,
		1'b0, x_ff, c_ff}; // [R7] [R10] [R11]
	wire [11:0]    mem_idx = {obj_type, rung_ff, slot_ff}; // [R15]
	wire [31:0]    pword   = prog_mem[mem_idx];
	lre_contact_t  cword;
	lre_coil_t     oword;
	assign cword = lre_contact_t'(pword);
	assign oword = lre_coil_t'(pword);
	wire           c_val   = src_vec[cword.src];
	wire           c_eff   = (cword.kind == LRE_K_NC || cword.kind == LRE_K_OR_NC) ?
		~c_val : c_val; // [R12] [R13]
	wire           c_or    = cword.kind == LRE_K_OR_NO || cword.kind == LRE_K_OR_NC;
	wire           at_coil = state_ff == S_SCAN && slot_ff == `LRE_COIL_SLOT;
	wire           rung_v  = any_ff & (par_ff | ser_ff);
	wire           coil_c  = at_coil && oword.okind == LRE_O_COIL && !oword.target[7];
	wire           coil_y  = at_coil && oword.okind == LRE_O_COIL &&
		oword.target[7:4] == 4'(`LRE_SRC_Y >> 4);

	// Measurement events
	wire err_q   = meas.err && meas.err_code != `LRE_ERR_EX0 &&
		meas.err_code != `LRE_ERR_EX1 && meas.err_code != `LRE_ERR_EX2 &&
		meas.err_code != `LRE_ERR_EX3; // [R3]
	wire light_bad = illum.cam0 > light0_ff[15:8] || illum.cam0 < light0_ff[7:0] ||
		illum.cam1 > light1_ff[15:8] || illum.cam1 < light1_ff[7:0]; // [R2]
	wire scan_go = meas.done && scan_en && state_ff == S_IDLE;

	// ==========================================================
	// Scan sequencer: one program word per cycle, rungs strictly in order
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= S_IDLE;
			rung_ff  <= 4'h0;
			slot_ff  <= 4'h0;
		end else begin
			unique case (state_ff)
				S_IDLE: begin
					rung_ff <= 4'h0;
					slot_ff <= 4'h0;
					if (scan_go)
						state_ff <= S_SCAN;
				end
				S_SCAN: begin
					if (slot_ff == `LRE_COIL_SLOT) begin
						slot_ff <= 4'h0;
						rung_ff <= rung_ff + 4'h1;
						if (rung_ff == 4'(RUNGS - 1))
							state_ff <= S_FINISH; // [R17]
					end else begin
						slot_ff <= slot_ff + 4'h1;
					end
				end
				S_FINISH: state_ff <= S_IDLE;
			endcase
		end
	end

	// Rung accumulator: series AND, an OR contact closes the branch above it
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ser_ff <= 1'b1;
			par_ff <= 1'b0;
			any_ff <= 1'b0;
		end else if (state_ff != S_SCAN || at_coil) begin
			ser_ff <= 1'b1;
			par_ff <= 1'b0;
			any_ff <= 1'b0;
		end else if (cword.kind != LRE_K_NONE) begin
			any_ff <= 1'b1;
			if (c_or) begin
				par_ff <= par_ff | ser_ff; // [R14]
				ser_ff <= c_eff;
			end else begin
				ser_ff <= ser_ff & c_eff; // [R17]
			end
		end
	end

	// ==========================================================
	// Auxiliary relays; hardware-owned ones are refreshed by measurement events
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			c_ff <= 128'h0;
		end else begin
			if (coil_c)
				c_ff[oword.target[6:0]] <= rung_v;
			c_ff[`LRE_RLY_LIGHT] <= ~light_bad; // [R2]
			if (meas.start) begin
				c_ff[`LRE_RLY_DONE]  <= 1'b0; // [R4]
				c_ff[`LRE_RLY_ERROR] <= 1'b0;
			end
			if (err_q)
				c_ff[`LRE_RLY_ERROR] <= 1'b1; // [R3]
			if (meas.done && state_ff == S_IDLE) begin
				c_ff[`LRE_RLY_DONE]  <= 1'b1; // [R4]
				c_ff[`LRE_RLY_FINAL] <= meas.items_ok & ~err_q &
					~c_ff[`LRE_RLY_ERROR]; // [R16]
			end
		end
	end

	// Output terminal image and the programmable-verdict usage flag
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			y_ff         <= 16'h0000;
			prog_used_ff <= 1'b0;
		end else begin
			if (coil_y)
				y_ff[oword.target[3:0]] <= rung_v;
			if (scan_go)
				prog_used_ff <= 1'b0;
			else if (coil_c && oword.target[6:0] == `LRE_RLY_PROG)
				prog_used_ff <= 1'b1;
		end
	end

	// Pins change only once the whole program has run
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			y_out_ff   <= 16'h0000;
			verdict_ff <= 1'b0;
		end else if (state_ff == S_FINISH) begin
			y_out_ff   <= y_ff; // [R17]
			verdict_ff <= prog_used_ff ? c_ff[`LRE_RLY_PROG] : c_ff[`LRE_RLY_FINAL]; // [R1]
		end
	end

	// ==========================================================
	// Timer base tick
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt_ff <= 17'h0_0000;
			tick_ff     <= 1'b0;
		end else begin
			tick_ff     <= tick_cnt_ff == 17'(TICK_CYC - 1);
			tick_cnt_ff <= (tick_cnt_ff == 17'(TICK_CYC - 1)) ? 17'h0_0000 :
				tick_cnt_ff + 17'h0_0001;
		end
	end

	// Latched timer and counter instruction inputs from the scan
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tm_in_ff  <= 8'h00;
			cn_hit_ff <= 8'h00;
			cn_val_ff <= 8'h00;
			for (int i = 0; i < 8; i++) begin
				tm_pre_ff[i] <= 10'h000;
				cn_pre_ff[i] <= 10'h000;
			end
		end else begin
			cn_hit_ff <= 8'h00;
			if (at_coil && oword.okind == LRE_O_TIMER) begin
				tm_in_ff[oword.target[2:0]]  <= rung_v;
				tm_pre_ff[oword.target[2:0]] <= oword.preset;
			end
			if (at_coil && oword.okind == LRE_O_COUNTER) begin
				cn_hit_ff[oword.target[2:0]] <= 1'b1;
				cn_val_ff[oword.target[2:0]] <= rung_v;
				cn_pre_ff[oword.target[2:0]] <= oword.preset;
			end
		end
	end

	// Per-channel timers and counters
	for (genvar g = 0; g < 8; g++) begin : g_chan
		logic [9:0] tm_cnt_ff, cn_cnt_ff;
		logic       cn_prev_ff, cn_term_ff;
		assign tm_term[g] = tm_in_ff[g] && tm_cnt_ff >= tm_pre_ff[g]; // [R8]
		assign cn_term[g] = cn_term_ff;

		// Timer runs while its input is on, restarts from zero when it drops
		always_ff @(posedge sys_clk or negedge rst_b) begin
			if (!rst_b) begin
				tm_cnt_ff <= 10'h000;
			end else if (!tm_in_ff[g]) begin
				tm_cnt_ff <= 10'h000; // [R8]
			end else if (tick_ff && tm_cnt_ff < tm_pre_ff[g]) begin
				tm_cnt_ff <= tm_cnt_ff + 10'h001;
			end
		end

		// Counter counts rising rung values; its clear relay wins over counting
		always_ff @(posedge sys_clk or negedge rst_b) begin
			if (!rst_b) begin
				cn_cnt_ff  <= 10'h000;
				cn_prev_ff <= 1'b0;
				cn_term_ff <= 1'b0;
			end else if (c_ff[`LRE_RLY_CLR0 + g]) begin
				cn_cnt_ff  <= 10'h000; // [R5] [R6]
				cn_term_ff <= 1'b0;    // [R9]
				cn_prev_ff <= cn_hit_ff[g] ? cn_val_ff[g] : cn_prev_ff;
			end else if (cn_hit_ff[g]) begin
				cn_prev_ff <= cn_val_ff[g];
				if (cn_val_ff[g] && !cn_prev_ff && !cn_term_ff) begin
					cn_cnt_ff <= cn_cnt_ff + 10'h001;
					if (cn_cnt_ff + 10'h001 >= cn_pre_ff[g])
						cn_term_ff <= 1'b1; // [R9]
				end
			end
		end
	end

	// ==========================================================
	// Interrupts: scan done, qualified error, light alarm; set wins over clear
	wire [2:0] irq_ev  = {light_bad & c_ff[`LRE_RLY_LIGHT], err_q, state_ff == S_FINISH};
	wire [2:0] irq_clr = (bus_do_w && avs_address == `LRE_REG_IRQ_STAT) ?
		avs_writedata[2:0] : 3'h0;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_stat_ff <= 3'h0;
			irq_ff      <= 1'b0;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_ev;
			irq_ff      <= |(((irq_stat_ff & ~irq_clr) | irq_ev) & irq_mask_ff);
		end
	end

	// Output drive
	assign avs_readdata     = rdata_ff;
	assign avs_waitrequest  = wait_ff;
	assign output_terminals = y_out_ff;
	assign verdict_ok       = verdict_ff;
	assign irq              = irq_ff;
endmodule

//--- tb/lre_evaluator_sva.sv
// Checker of the evaluator's bus handshake, scan timing and interrupt
`timescale 1ns/1ns
module lre_evaluator_sva #(
	parameter int TICK_CYC = 100000,
	parameter int RUNGS    = 16
) (
	// Clock and reset
	input wire logic                sys_clk,
	input wire logic                rst_b,
	// Avalon-MM slave
	input wire logic [7:0]          avs_address,
	input wire logic                avs_read,
	input wire logic                avs_write,
	input wire logic [31:0]         avs_writedata,
	input wire logic [31:0]         avs_readdata,
	input wire logic                avs_waitrequest,
	// Measurement engine
	input wire lre_pkg::lre_meas_t  meas,
	input wire lre_pkg::lre_light_t illum,
	input wire logic [15:0]         calc_result_terminals,
	// Pins and results
	input wire logic [6:0]          external_input_terminals,
	input wire logic [15:0]         output_terminals,
	input wire logic                verdict_ok,
	input wire logic                irq
);
	import lre_pkg::*;
	// ==========================================================
	// Scan, finish cycle and pin register; one cycle slack either side
	localparam int SD = 9 * RUNGS + 2;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// Bus handshake: exactly one wait state per access
	wait_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest did not drop after a request");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	wait_idle_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
		else $error("waitrequest low without a request");
	rdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read) || $past(avs_read, 2))
		else $error("read data changed without a read");
	unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address > 8'h24
		|-> avs_readdata == 32'h0)
		else $error("unmapped address read nonzero");
	// ==========================================================
	// Pins move only at the end of a scan started by done
	pins_scan_a: assert property ($changed(output_terminals) |-> $past(meas.done, SD - 1)
		|| $past(meas.done, SD) || $past(meas.done, SD + 1))
		else $error("output pins changed outside scan end");
	verdict_scan_a: assert property ($changed(verdict_ok) |-> $past(meas.done, SD - 1)
		|| $past(meas.done, SD) || $past(meas.done, SD + 1))
		else $error("verdict changed outside scan end");
	// Interrupt can only fall after a status clear or mask write
	irq_drop_a: assert property ($fell(irq) |-> $past(avs_write, 2) || $past(avs_write, 3))
		else $error("interrupt fell without a register write");
endmodule
bind lre_evaluator lre_evaluator_sva #(.TICK_CYC(TICK_CYC), .RUNGS(RUNGS)) chk_u (
	.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .meas(meas), .illum(illum),
	.calc_result_terminals(calc_result_terminals),
	.external_input_terminals(external_input_terminals),
	.output_terminals(output_terminals), .verdict_ok(verdict_ok), .irq(irq));

//--- tb/lre_ctl_model.sv
// Factory controller model: drives pins, light levels and measurement pulses
`timescale 1ns/1ns
module lre_ctl_model (
	// Clock
	input  wire logic                sys_clk,
	// Toward the evaluator
	output lre_pkg::lre_meas_t       meas,
	output lre_pkg::lre_light_t      illum,
	output logic [15:0]              calc_result_terminals,
	output logic [6:0]               external_input_terminals
);
	import lre_pkg::*;
	// Quiet inputs, both cameras mid-range
	initial begin
		meas = '0;
		illum = 16'h4040;
		calc_result_terminals = 16'h0000;
		external_input_terminals = 7'h00;
	end
	// Pins change after an edge; synchroniser delay is covered by measure
	task automatic set_pins(input logic [6:0] x, input logic [15:0] an);
		@(posedge sys_clk);
		external_input_terminals <= x;
		calc_result_terminals <= an;
	endtask
	// Light level is a plain level; let the relay refresh before looking
	task automatic set_light(input logic [7:0] c0, input logic [7:0] c1);
		@(posedge sys_clk);
		illum <= {c0, c1};
		repeat (4) @(posedge sys_clk);
	endtask
	// Start, then done with any error; tail outlasts scan and finish
	task automatic measure(input logic err, input logic [7:0] code, input logic ok,
		input logic fin);
		repeat (6) @(posedge sys_clk);
		meas <= 12'h800;
		@(posedge sys_clk);
		meas <= '0;
		@(posedge sys_clk);
		meas <= {1'b0, fin, err & fin, code, ok};
		@(posedge sys_clk);
		meas <= '0;
		repeat (26) @(posedge sys_clk);
	endtask
endmodule

//--- tb/lre_evaluator_tb.sv
// Testbench of the ladder relay evaluator
`timescale 1ns/1ns
`include "lre_consts.svh"
module lre_evaluator_tb;
	import lre_pkg::*;
	// ==========================================================
	// Bench signals
	logic               sys_clk = 1'b0;
	logic               rst_b = 1'b0;
	logic [7:0]         avs_address = 8'h00;
	logic               avs_read = 1'b0;
	logic               avs_write = 1'b0;
	logic [31:0]        avs_writedata = 32'h0;
	logic [31:0]        avs_readdata;
	logic               avs_waitrequest;
	lre_meas_t          meas;
	lre_light_t         illum;
	logic [15:0]        calc_result_terminals;
	logic [6:0]         external_input_terminals;
	logic [15:0]        output_terminals;
	logic               verdict_ok;
	logic               irq;
	int                 errors = 0;
	int                 samples_checked = 0;
	int                 i;
	logic [31:0]        q;
	logic               want0;
	logic               qual;
	// Tables: {in0,in1,res0}, {err,code,ok}, {in3,in4,terminal}, {cam0,cam1,ok}
	logic [2:0]         pat [4] = '{3'b100, 3'b110, 3'b001, 3'b000};
	logic [9:0]         etab [6] = '{10'h269, 10'h26b, 10'h26d, 10'h27d, 10'h225, 10'h000};
	logic [2:0]         ctab [5] = '{3'b100, 3'b000, 3'b101, 3'b001, 3'b010};
	logic [16:0]        ltab [3] = '{{16'h4090, 1'b0}, {16'h0540, 1'b0}, {16'h4040, 1'b1}};
	always #50 sys_clk = ~sys_clk;
	lre_evaluator #(.TICK_CYC(4), .RUNGS(2)) dut_u (
		.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .meas(meas), .illum(illum),
		.calc_result_terminals(calc_result_terminals),
		.external_input_terminals(external_input_terminals),
		.output_terminals(output_terminals), .verdict_ok(verdict_ok), .irq(irq));
	lre_ctl_model ctl_u (.sys_clk(sys_clk), .meas(meas), .illum(illum),
		.calc_result_terminals(calc_result_terminals),
		.external_input_terminals(external_input_terminals));
	// ==========================================================
	// Bus access: hold until waitrequest is sampled low at a rising edge
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rq);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0 && n < 20) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 20) begin
			$display("BAD waitrequest expected 0 seen %b", avs_waitrequest);
			errors++;
		end
		rq = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		acc(1'b1, a, d, dummy);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask
	function automatic logic [31:0] ct(lre_kind_t k, logic [7:0] s);
		return {21'h0, k, s};
	endfunction
	function automatic logic [31:0] co(lre_okind_t k, logic [7:0] t, logic [9:0] p);
		return {12'h0, p, k, t};
	endfunction
	// One rung: two contacts, six empty slots, coil word
	task automatic rung(input logic [3:0] t, input logic [3:0] r, input logic [31:0] c0,
		input logic [31:0] c1, input logic [31:0] cl);
		int k;
		wr(`LRE_REG_PROG_ADDR, {20'h0, t, r, 4'h0});
		wr(`LRE_REG_PROG_DATA, c0);
		wr(`LRE_REG_PROG_DATA, c1);
		for (k = 0; k < 6; k++) begin
			wr(`LRE_REG_PROG_DATA, 32'h0);
		end
		wr(`LRE_REG_PROG_DATA, cl);
	endtask
	task automatic print_verdict();
		$display("TB: checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Watchdog: the tests need well under 5000 cycles
	initial begin
		repeat (40000) @(posedge sys_clk);
		errors++;
		print_verdict();
	end
	// ==========================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		rung(3, 0, ct(LRE_K_NO, 8'h80), ct(LRE_K_NC, 8'h81), co(LRE_O_COIL, 8'hb0, 10'd0));
		rung(3, 1, ct(LRE_K_NO, 8'ha0), ct(LRE_K_OR_NO, 8'hb0), co(LRE_O_COIL, 8'hb1, 10'd0));
		rung(5, 0, ct(LRE_K_NO, 8'h82), 32'h0, co(LRE_O_COIL, 8'h74, 10'd0));
		rung(5, 1, 32'h0, 32'h0, 32'h0);
		rung(7, 0, ct(LRE_K_NO, 8'h83), 32'h0, co(LRE_O_COUNTER, 8'h00, 10'd2));
		rung(7, 1, ct(LRE_K_NO, 8'h84), 32'h0, co(LRE_O_COIL, 8'h78, 10'd0));
		rung(9, 0, ct(LRE_K_NO, 8'h85), 32'h0, co(LRE_O_TIMER, 8'h01, 10'd3));
		rung(9, 1, 32'h0, 32'h0, 32'h0);
		wr(`LRE_REG_IRQ_MASK, 32'h4);
		// Series, inverted and OR contacts; two scans so the read-back settles
		wr(`LRE_REG_CTRL, 32'h31);
		for (i = 0; i < 4; i++) begin
			ctl_u.set_pins({5'h0, pat[i][1], pat[i][2]}, {15'h0, pat[i][0]});
			ctl_u.measure(1'b0, 8'h00, 1'b1, 1'b1);
			ctl_u.measure(1'b0, 8'h00, 1'b1, 1'b1);
			want0 = pat[i][2] & ~pat[i][1];
			acc(1'b0, `LRE_REG_OUTPUTS, 32'h0, q);
			chk("outputs", {30'h0, pat[i][0] | want0, want0}, q);
			chk("output pins", {30'h0, pat[i][0] | want0, want0}, 32'(output_terminals));
		end
		// Final verdict against error codes and item results
		for (i = 0; i < 6; i++) begin
			ctl_u.measure(etab[i][9], etab[i][8:1], etab[i][0], 1'b1);
			qual = etab[i][9] && !(etab[i][8:1] inside {`LRE_ERR_EX0, `LRE_ERR_EX1,
				`LRE_ERR_EX2, `LRE_ERR_EX3});
			acc(1'b0, `LRE_REG_STATUS, 32'h0, q);
			chk("verdict", 32'(etab[i][0] & !qual), 32'(verdict_ok));
			chk("error relay", 32'(qual), 32'(q[6]));
			chk("done relay", 32'h1, 32'(q[7]));
		end
		ctl_u.measure(1'b0, 8'h00, 1'b1, 1'b0);
		acc(1'b0, `LRE_REG_STATUS, 32'h0, q);
		chk("done cleared", 32'h0, 32'(q[7]));
		// Programmable relay overrides the final relay
		wr(`LRE_REG_CTRL, 32'h51);
		for (i = 0; i < 2; i++) begin
			ctl_u.set_pins(7'(i << 2), 16'h0);
			ctl_u.measure(1'b0, 8'h00, 1'b1, 1'b1);
			chk("programmed verdict", 32'(i), 32'(verdict_ok));
		end
		// Counter: count on rising input, hold, clear from later rung
		wr(`LRE_REG_CTRL, 32'h71);
		for (i = 0; i < 5; i++) begin
			ctl_u.set_pins({2'h0, ctab[i][1], ctab[i][2], 3'h0}, 16'h0);
			ctl_u.measure(1'b0, 8'h00, 1'b1, 1'b1);
			acc(1'b0, `LRE_REG_TERMS, 32'h0, q);
			chk("counter terminal", 32'(ctab[i][0]), 32'(q[8]));
		end
		// Timer: times out while input on, drops when input goes off
		wr(`LRE_REG_CTRL, 32'h91);
		for (i = 1; i >= 0; i--) begin
			ctl_u.set_pins(7'(i << 5), 16'h0);
			ctl_u.measure(1'b0, 8'h00, 1'b1, 1'b1);
			acc(1'b0, `LRE_REG_TERMS, 32'h0, q);
			chk("timer terminal", 32'(i), 32'(q[1]));
		end
		// Light limits 80..10 on both cameras; alarm event raises masked-in irq
		chk("irq masked", 32'h0, 32'(irq));
		wr(`LRE_REG_LIGHT0, 32'h8010);
		wr(`LRE_REG_LIGHT1, 32'h8010);
		for (i = 0; i < 3; i++) begin
			ctl_u.set_light(ltab[i][16:9], ltab[i][8:1]);
			acc(1'b0, `LRE_REG_STATUS, 32'h0, q);
			chk("light relay", 32'(ltab[i][0]), 32'(q[5]));
		end
		chk("irq", 32'h1, 32'(irq));
		wr(`LRE_REG_IRQ_STAT, 32'h7);
		repeat (3) @(posedge sys_clk);
		chk("irq cleared", 32'h0, 32'(irq));
		acc(1'b0, 8'h40, 32'h0, q);
		chk("unmapped", 32'h0, q);
		print_verdict();
	end
endmodule
